// *** rtl/adccfg_pkg.sv ***
// Package of register map, field layout and encodings for the ADC configuration bank
package adccfg_pkg;
  // ****************************************
  // Register offsets (byte registers, word aligned on the bus)
  // ****************************************
  localparam logic [3:0] REF_MON_IDX = 4'h2; // Reference and monitor control
  localparam logic [3:0] GAIN_RATE_IDX = 4'h3; // Gain and rate control
  localparam logic [3:0] OFS_LOW_IDX = 4'h4; // Offset coefficient low byte
  localparam logic [3:0] OFS_MID_IDX = 4'h5; // Offset coefficient mid byte
  localparam logic [3:0] OFS_HIGH_IDX = 4'h6; // Offset coefficient high byte
  localparam logic [3:0] FS_LOW_IDX = 4'h7; // Full-scale coefficient low byte
  localparam logic [3:0] FS_MID_IDX = 4'h8; // Full-scale coefficient mid byte
  localparam logic [3:0] FS_HIGH_IDX = 4'h9; // Full-scale coefficient high byte
  localparam logic [3:0] EXC_REV_IDX = 4'ha; // Excitation and revision
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] REF_MON_RST = 8'h00;
  localparam logic [7:0] GAIN_RATE_RST = 8'h00;
  localparam logic [23:0] OFS_RST = 24'h000000;
  localparam logic [3:0] EXC_RST = 4'h0;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CLK_SRC_BIT = 7;
  localparam int VREF_HI = 6;
  localparam int VREF_LO = 5;
  localparam int REFSEL_HI = 4;
  localparam int REFSEL_LO = 3;
  localparam int MON_HI = 2;
  localparam int MON_LO = 0;
  localparam int GAIN_HI = 6;
  localparam int GAIN_LO = 4;
  localparam int RATE_HI = 3;
  localparam int RATE_LO = 0;
  localparam int REV_HI = 7;
  localparam int REV_LO = 4;
  localparam int RDY_BIT = 3;
  localparam int EXCITATION_MAGNITUDE_HI = 2;
  localparam int EXCITATION_MAGNITUDE_LO = 0;
  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] VREF_OFF = 2'h0;
  localparam logic [1:0] VREF_ON = 2'h1;
  localparam logic [1:0] REFSEL_PAIR0 = 2'h0;
  localparam logic [1:0] REFSEL_PAIR1 = 2'h1;
  localparam logic [1:0] REFSEL_ONBOARD = 2'h2;
  localparam logic [1:0] REFSEL_TIED = 2'h3;
  localparam logic [2:0] MON_NORMAL = 3'h0;
  localparam logic [2:0] MON_OFFSET = 3'h1;
  localparam logic [2:0] GAIN_ONE = 3'h0;
  localparam logic [3:0] RATE_TOP_CODE = 4'h9;
  localparam logic [3:0] RATE_MAX_IDX = 4'h9;
endpackage

// *** rtl/adccfg_fs_trim.sv ***
// Factory full-scale trim table, one 24-bit value per gain code
`timescale 1ns/1ps
module adccfg_fs_trim #(
  parameter logic [23:0] TRIM0 = 24'h400000, // Arbitrary trim values
  parameter logic [23:0] TRIM1 = 24'h400100,
  parameter logic [23:0] TRIM2 = 24'h400200,
  parameter logic [23:0] TRIM3 = 24'h400300,
  parameter logic [23:0] TRIM4 = 24'h400400,
  parameter logic [23:0] TRIM5 = 24'h400500,
  parameter logic [23:0] TRIM6 = 24'h400600,
  parameter logic [23:0] TRIM7 = 24'h400700
) (
  input wire logic [2:0] gain_code,
  output logic [23:0] trim_value
);
  // Table lookup on the programmed gain code
  always_comb begin
    unique case (gain_code)
      3'h0: trim_value = TRIM0;
      3'h1: trim_value = TRIM1;
      3'h2: trim_value = TRIM2;
      3'h3: trim_value = TRIM3;
      3'h4: trim_value = TRIM4;
      3'h5: trim_value = TRIM5;
      3'h6: trim_value = TRIM6;
      default: trim_value = TRIM7;
    endcase
  end
endmodule

// *** rtl/adccfg_sync.sv ***
// Two flip-flop synchroniser for a level from a pin
`timescale 1ns/1ps
module adccfg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // First stage, read only by second
  // Two stages; only the second is visible
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// *** rtl/adccfg_bank.sv ***
// Configuration and calibration register bank with Avalon-MM slave
`timescale 1ns/1ps
module adccfg_bank
  import adccfg_pkg::*;
#(
  parameter logic [3:0] REV_CODE = 4'h5, // Arbitrary revision value
  parameter int ADDR_W = 6
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EXT_OSC_ACTIVE,
  input wire logic CONVERTING,
  input wire logic SHUTDOWN_CMD,
  input wire logic START_PIN,
  output logic REF_ENABLE,
  output logic [1:0] REF_SOURCE,
  output logic REF_TIE_PAIR0,
  output logic [2:0] MONITOR_SELECT,
  output logic MONITOR_OVERRIDE,
  output logic INPUTS_SHORTED,
  output logic [7:0] EFFECTIVE_GAIN,
  output logic [11:0] OUTPUT_RATE_SPS,
  output logic [23:0] OFFSET_COEF,
  output logic [23:0] FULLSCALE_COEF,
  output logic READY_ON_OUTPUT,
  output logic [10:0] EXCITATION_UA
);
  import adccfg_pkg::*;

  // Elaboration check: the register index needs address bits 5:2
  if (ADDR_W < 6) begin : g_addr_too_narrow
    $error("ADDR_W must cover byte offset 0x28");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic ext_osc_s; // Clock source flag, synchronised
  logic start_s; // Start pin level, synchronised
  adccfg_sync #(.WIDTH(2)) u_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .async_in({EXT_OSC_ACTIVE, START_PIN}),
    .sync_out({ext_osc_s, start_s})
  );

  // ****************************************
  // Register storage
  // ****************************************
  logic [6:0] ref_mon_q; // Reference and monitor fields, bit 7 is live
  logic [7:0] gain_rate_q; // Gain and rate control
  logic [23:0] ofs_q; // Offset coefficient
  logic [23:0] fs_q; // Full-scale coefficient
  logic [3:0] exc_q; // Ready mode and magnitude
  logic init_q; // Low for first cycle after reset
  logic [2:0] gain_prev_q; // Gain code seen last cycle
  logic [23:0] trim_val; // Trim value for current gain
  logic req_done_q; // Answer cycle marker

  // ****************************************
  // Bus decode
  // ****************************************
  logic [3:0] idx; // Register index from word address
  logic hit; // Address maps to a register
  logic wr_go; // Write accepted this cycle
  logic rd_go; // Read accepted this cycle
  logic [7:0] wbyte; // Write data low byte
  logic wlane; // Low byte lane enabled

  assign idx = AVS_ADDRESS[5:2];
  assign hit = (AVS_ADDRESS[1:0] == 2'h0) && ((AVS_ADDRESS >> 6) == '0)
               && (idx >= REF_MON_IDX) && (idx <= EXC_REV_IDX);
  // Accept on the second cycle of each request: one wait state
  assign wr_go = AVS_WRITE && req_done_q;
  assign rd_go = AVS_READ && req_done_q;
  assign wbyte = AVS_WRITEDATA[7:0];
  assign wlane = AVS_BYTEENABLE[0];

  // Function decoding a write strobe to one register
  function automatic logic wr_to(input logic [3:0] which, input logic [3:0] at,
                                 input logic go, input logic en, input logic h);
    wr_to = go && en && h && (at == which);
  endfunction

  // Wait-request sequencer: low exactly on the accept cycle
  // Waitrequest kept as its own flop so the bus sees no decode glitches
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      req_done_q <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
    end else if ((AVS_READ || AVS_WRITE) && !req_done_q) begin
      req_done_q <= 1'b1;
      AVS_WAITREQUEST <= 1'b0;
    end else begin
      req_done_q <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  // ****************************************
  // Reference and monitor control
  // ****************************************
  // reserved bits are host's duty; stored bits written as given
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ref_mon_q <= REF_MON_RST[6:0];
    end else if (wr_to(REF_MON_IDX, idx, wr_go, wlane, hit)) begin
      ref_mon_q <= wbyte[6:0];
    end
  end

  // ****************************************
  // Gain and rate control
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      gain_rate_q <= GAIN_RATE_RST;
    end else if (wr_to(GAIN_RATE_IDX, idx, wr_go, wlane, hit)) begin
      gain_rate_q <= wbyte;
    end
  end

  // ****************************************
  // Offset coefficient
  // ****************************************
  // three bytes, lowest address holds LSB
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ofs_q <= OFS_RST;
    end else begin
      if (wr_to(OFS_LOW_IDX, idx, wr_go, wlane, hit)) ofs_q[7:0] <= wbyte;
      if (wr_to(OFS_MID_IDX, idx, wr_go, wlane, hit)) ofs_q[15:8] <= wbyte;
      if (wr_to(OFS_HIGH_IDX, idx, wr_go, wlane, hit)) ofs_q[23:16] <= wbyte;
    end
  end

  // ****************************************
  // Full-scale coefficient and trim reload
  // ****************************************
  adccfg_fs_trim u_trim (
    .gain_code(gain_rate_q[GAIN_HI:GAIN_LO]),
    .trim_value(trim_val)
  );

  // Gain tracking; reload fires one cycle after a gain change
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      init_q <= 1'b0;
      gain_prev_q <= GAIN_ONE;
    end else begin
      init_q <= 1'b1;
      gain_prev_q <= gain_rate_q[GAIN_HI:GAIN_LO];
    end
  end

  // Trim load wins over a host write in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      fs_q <= '0;
    // load trim of the reset gain
    end else if (!init_q) begin
      fs_q <= trim_val;
    // gain change overwrites any written value
    end else if (gain_prev_q != gain_rate_q[GAIN_HI:GAIN_LO]) begin
      fs_q <= trim_val;
    end else begin
      // three bytes, lowest address holds LSB
      if (wr_to(FS_LOW_IDX, idx, wr_go, wlane, hit)) fs_q[7:0] <= wbyte;
      if (wr_to(FS_MID_IDX, idx, wr_go, wlane, hit)) fs_q[15:8] <= wbyte;
      if (wr_to(FS_HIGH_IDX, idx, wr_go, wlane, hit)) fs_q[23:16] <= wbyte;
    end
  end

  // ****************************************
  // Excitation and revision
  // ****************************************
  // only low nibble is stored; revision bits ignore writes
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      exc_q <= EXC_RST;
    end else if (wr_to(EXC_REV_IDX, idx, wr_go, wlane, hit)) begin
      exc_q <= wbyte[RDY_BIT:EXCITATION_MAGNITUDE_LO];
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Read mux; unmapped offsets answer zero
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      AVS_READDATA <= '0;
    end else if (AVS_READ && !req_done_q) begin
      AVS_READDATA <= '0;
      if (hit) begin
        unique case (idx)
          REF_MON_IDX: AVS_READDATA[7:0] <= {ext_osc_s, ref_mon_q};
          GAIN_RATE_IDX: AVS_READDATA[7:0] <= gain_rate_q;
          OFS_LOW_IDX: AVS_READDATA[7:0] <= ofs_q[7:0];
          OFS_MID_IDX: AVS_READDATA[7:0] <= ofs_q[15:8];
          OFS_HIGH_IDX: AVS_READDATA[7:0] <= ofs_q[23:16];
          FS_LOW_IDX: AVS_READDATA[7:0] <= fs_q[7:0];
          FS_MID_IDX: AVS_READDATA[7:0] <= fs_q[15:8];
          FS_HIGH_IDX: AVS_READDATA[7:0] <= fs_q[23:16];
          default: AVS_READDATA[7:0] <= {REV_CODE, exc_q};
        endcase
      end
    end
  end

  // ****************************************
  // Decoded outputs
  // ****************************************
  // Gain code to gain factor
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    gain_of = 8'h01 << code;
  endfunction

  // Rate code to samples per second
  function automatic logic [11:0] rate_of(input logic [3:0] code);
    unique case (code)
      4'h0: rate_of = 12'h005;
      4'h1: rate_of = 12'h00a;
      4'h2: rate_of = 12'h014;
      4'h3: rate_of = 12'h028;
      4'h4: rate_of = 12'h050;
      4'h5: rate_of = 12'h0a0;
      4'h6: rate_of = 12'h140;
      4'h7: rate_of = 12'h280;
      4'h8: rate_of = 12'h3e8;
      default: rate_of = 12'h7d0;
    endcase
  endfunction

  // Magnitude code to microamps
  function automatic logic [10:0] uamp_of(input logic [2:0] code);
    unique case (code)
      3'h0: uamp_of = 11'h000;
      3'h1: uamp_of = 11'h032;
      3'h2: uamp_of = 11'h064;
      3'h3: uamp_of = 11'h0fa;
      3'h4: uamp_of = 11'h1f4;
      3'h5: uamp_of = 11'h2ee;
      3'h6: uamp_of = 11'h3e8;
      default: uamp_of = 11'h5dc;
    endcase
  endfunction

  logic [1:0] vref_f; // Reference control field
  logic [2:0] mon_f; // Monitor field
  assign vref_f = ref_mon_q[VREF_HI:VREF_LO];
  assign mon_f = ref_mon_q[MON_HI:MON_LO];

  // Registered copies of all decoded controls
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      REF_ENABLE <= 1'b0;
      REF_SOURCE <= REFSEL_PAIR0;
      REF_TIE_PAIR0 <= 1'b0;
      MONITOR_SELECT <= MON_NORMAL;
      MONITOR_OVERRIDE <= 1'b0;
      INPUTS_SHORTED <= 1'b0;
      EFFECTIVE_GAIN <= 8'h01;
      OUTPUT_RATE_SPS <= 12'h005;
      OFFSET_COEF <= OFS_RST;
      FULLSCALE_COEF <= '0;
      READY_ON_OUTPUT <= 1'b0;
      EXCITATION_UA <= 11'h000;
    end else begin
      // fixed off or on; follows conversion otherwise
      if (vref_f == VREF_OFF) REF_ENABLE <= 1'b0;
      else if (vref_f == VREF_ON) REF_ENABLE <= 1'b1;
      else REF_ENABLE <= CONVERTING && start_s && !SHUTDOWN_CMD;
      REF_SOURCE <= (ref_mon_q[REFSEL_HI:REFSEL_LO] == REFSEL_TIED) ? REFSEL_ONBOARD
                    : ref_mon_q[REFSEL_HI:REFSEL_LO];
      REF_TIE_PAIR0 <= (ref_mon_q[REFSEL_HI:REFSEL_LO] == REFSEL_TIED);
      MONITOR_SELECT <= mon_f;
      // any non-normal code overrides inputs and bias
      MONITOR_OVERRIDE <= (mon_f != MON_NORMAL);
      // offset code shorts inputs to midsupply
      INPUTS_SHORTED <= (mon_f == MON_OFFSET);
      // forced unity gain; otherwise programmed gain
      EFFECTIVE_GAIN <= (mon_f > MON_OFFSET) ? 8'h01 : gain_of(gain_rate_q[GAIN_HI:GAIN_LO]);
      // rate table; high codes at top rate
      OUTPUT_RATE_SPS <= rate_of(gain_rate_q[RATE_HI:RATE_LO]);
      OFFSET_COEF <= ofs_q;
      FULLSCALE_COEF <= fs_q;
      READY_ON_OUTPUT <= exc_q[RDY_BIT];
      // excitation magnitude; host keeps reference on
      EXCITATION_UA <= uamp_of(exc_q[EXCITATION_MAGNITUDE_HI:EXCITATION_MAGNITUDE_LO]);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  fixed_ref_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (vref_f == VREF_ON) |=> REF_ENABLE) else $error("reference not on");
  follow_ref_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (vref_f[1] && !start_s) |=> !REF_ENABLE) else $error("reference not off");
  tie_ref_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (ref_mon_q[REFSEL_HI:REFSEL_LO] == REFSEL_TIED) |=> (REF_TIE_PAIR0
    && REF_SOURCE == REFSEL_ONBOARD)) else $error("tie wrong");
  override_mon_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (mon_f != MON_NORMAL) |=> MONITOR_OVERRIDE) else $error("no override");
  forced_gain_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (mon_f > MON_OFFSET) |=> (EFFECTIVE_GAIN == 8'h01)) else $error("gain not 1");
  top_rate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (gain_rate_q[RATE_HI:RATE_LO] >= RATE_TOP_CODE) |=> (OUTPUT_RATE_SPS == 12'h7d0))
    else $error("rate not top");
  trim_reload_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (init_q && $changed(gain_rate_q[GAIN_HI:GAIN_LO])) |=> (fs_q == trim_val))
    else $error("trim not reloaded");
  rev_keep_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (AVS_READ && !AVS_WAITREQUEST && hit && idx == EXC_REV_IDX && $past(AVS_READ))
    |-> (AVS_READDATA[7:4] == REV_CODE)) else $error("revision changed");
  ofs_low_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    wr_to(OFS_LOW_IDX, idx, wr_go, wlane, hit) |=> (ofs_q[7:0] == $past(wbyte)))
    else $error("offset byte lost");
endmodule

// *** verification/adccfg_host.sv ***
// Host controller model: bus master for the configuration bank
`timescale 1ns/1ps
module adccfg_host
  import adccfg_pkg::*;
(
  input wire logic clk,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  int timeouts = 0; // Requests never answered
  logic lane_en = 1'b1; // Byte lane 0 enable for the next transfer
  // ****************************************
  // Idle bus at time zero
  // ****************************************
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
  end
  // ****************************************
  // One transfer
  // ****************************************
  // Slave outputs are read at the rising edge before its flops update,
  // so the values seen are those the slave samples with the request
  task automatic access(input logic [3:0] idx, input logic wr, input logic [7:0] data,
                        output logic [31:0] rdata);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    rdata = 32'h0;
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, data};
    avs_byteenable <= {3'h0, lane_en};
    do begin
      @(posedge clk);
      n++;
      ok = (avs_waitrequest === 1'b0);
      rdata = avs_readdata;
    end while (!ok && n < 20);
    if (!ok) begin
      timeouts++;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Idle edge so the next request never reassigns in this step
    @(posedge clk);
  endtask
  // Register write
  task automatic wr(input logic [3:0] idx, input logic [7:0] data);
    logic [31:0] dummy;
    access(idx, 1'b1, (idx == GAIN_RATE_IDX) ? (data & 8'h7f) : data, dummy);
  endtask
  // Register read
  task automatic rd(input logic [3:0] idx, output logic [31:0] data);
    access(idx, 1'b0, 8'h00, data);
  endtask
endmodule

// *** verification/adc_config_register_bank_bench.sv ***
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module adc_config_register_bank_bench;
  import adccfg_pkg::*;
  localparam logic [3:0] REV = 4'h5; // Arbitrary revision value
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic ext_osc_active = 1'b0;
  logic converting = 1'b0;
  logic shutdown_cmd = 1'b0;
  logic start_pin = 1'b0;
  logic ref_enable, ref_tie_pair0, monitor_override, inputs_shorted, ready_on_output;
  logic [1:0] ref_source;
  logic [2:0] monitor_select;
  logic [7:0] effective_gain;
  logic [11:0] output_rate_sps;
  logic [23:0] offset_coef, fullscale_coef;
  logic [10:0] excitation_ua;
  int mismatches = 0;
  int check_count = 0;
  logic exp_on;
  // Rate and excitation tables in SPS and uA
  logic [11:0] rate_tab [16] = '{12'h005, 12'h00a, 12'h014, 12'h028, 12'h050, 12'h0a0,
    12'h140, 12'h280, 12'h3e8, 12'h7d0, 12'h7d0, 12'h7d0, 12'h7d0, 12'h7d0, 12'h7d0, 12'h7d0};
  logic [10:0] exc_tab [8] = '{11'h000, 11'h032, 11'h064, 11'h0fa, 11'h1f4, 11'h2ee,
    11'h3e8, 11'h5dc};
  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;
  adccfg_bank #(.REV_CODE(REV), .ADDR_W(6)) i_dut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .EXT_OSC_ACTIVE(ext_osc_active), .CONVERTING(converting), .SHUTDOWN_CMD(shutdown_cmd),
    .START_PIN(start_pin), .REF_ENABLE(ref_enable), .REF_SOURCE(ref_source),
    .REF_TIE_PAIR0(ref_tie_pair0), .MONITOR_SELECT(monitor_select),
    .MONITOR_OVERRIDE(monitor_override), .INPUTS_SHORTED(inputs_shorted),
    .EFFECTIVE_GAIN(effective_gain), .OUTPUT_RATE_SPS(output_rate_sps),
    .OFFSET_COEF(offset_coef), .FULLSCALE_COEF(fullscale_coef),
    .READY_ON_OUTPUT(ready_on_output), .EXCITATION_UA(excitation_ua));
  adccfg_host i_host (
    .clk(clk_sys), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  // ****************************************
  // Helpers
  // ****************************************
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read a register and compare
  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    i_host.rd(idx, d);
    check(d, {24'h000000, exp});
  endtask
  // Decoded outputs lag one cycle, synchronisers two more
  task automatic settle;
    repeat (4) @(posedge clk_sys);
  endtask
  // Verdict and end of run
  task automatic stop_test;
    mismatches += i_host.timeouts;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Cut a hang short; the whole sequence needs about 660 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    // Reset state
    check(32'(effective_gain), 32'h1);
    check(32'(output_rate_sps), 32'h5);
    check(32'(fullscale_coef), 32'h400000);
    rdchk(GAIN_RATE_IDX, 8'h00);
    for (int i = 0; i < 3; i++) rdchk(4'(OFS_LOW_IDX + i), 8'h00);
    rdchk(FS_HIGH_IDX, 8'h40);
    rdchk(EXC_REV_IDX, {REV, 4'h0});
    // Clock flag follows the pin, ignores writes
    i_host.wr(REF_MON_IDX, 8'h80);
    rdchk(REF_MON_IDX, 8'h00);
    ext_osc_active <= 1'b1;
    settle();
    rdchk(REF_MON_IDX, 8'h80);
    ext_osc_active <= 1'b0;
    // Reference control against every condition mix
    for (int v = 0; v < 4; v++) begin
      i_host.wr(REF_MON_IDX, {1'b0, 2'(v), 5'h00});
      for (int c = 0; c < 8; c++) begin
        converting <= c[0];
        start_pin <= c[1];
        shutdown_cmd <= c[2];
        settle();
        exp_on = (v == 1) || (v >= 2 && c[0] && c[1] && !c[2]);
        check(32'(ref_enable), 32'(exp_on));
      end
    end
    // Reference select codes
    for (int s = 0; s < 4; s++) begin
      i_host.wr(REF_MON_IDX, {3'h0, 2'(s), 3'h0});
      settle();
      check(32'(ref_source), (s == 3) ? 32'h2 : 32'(s));
      check(32'(ref_tie_pair0), 32'(s == 3));
    end
    // Monitor codes with gain 8 programmed
    i_host.wr(GAIN_RATE_IDX, 8'h30);
    for (int m = 0; m < 9; m++) begin
      i_host.wr(REF_MON_IDX, {5'h00, 3'(m % 8)});
      settle();
      check(32'(monitor_select), 32'(m % 8));
      check(32'(monitor_override), 32'(m % 8 != 0));
      check(32'(inputs_shorted), 32'(m % 8 == 1));
      check(32'(effective_gain), (m % 8 < 2) ? 32'h8 : 32'h1);
    end
    // Every rate code, gain changing each time
    for (int r = 0; r < 16; r++) begin
      i_host.wr(GAIN_RATE_IDX, {1'b0, 3'(r % 8), 4'(r)});
      settle();
      check(32'(effective_gain), 32'h1 << (r % 8));
      check(32'(output_rate_sps), 32'(rate_tab[r]));
      check(32'(fullscale_coef), 32'(32'h400000 + 32'h100 * (r % 8)));
      rdchk(GAIN_RATE_IDX, {1'b0, 3'(r % 8), 4'(r)});
    end
    // Coefficient bytes, low byte first
    i_host.wr(OFS_LOW_IDX, 8'h11);
    i_host.wr(OFS_MID_IDX, 8'h22);
    i_host.wr(OFS_HIGH_IDX, 8'h33);
    i_host.wr(FS_LOW_IDX, 8'ha1);
    i_host.wr(FS_MID_IDX, 8'hb2);
    i_host.wr(FS_HIGH_IDX, 8'hc3);
    settle();
    check(32'(offset_coef), 32'h332211);
    check(32'(fullscale_coef), 32'hc3b2a1);
    rdchk(OFS_MID_IDX, 8'h22);
    rdchk(FS_LOW_IDX, 8'ha1);
    // Gain change overwrites the written full-scale value
    i_host.wr(GAIN_RATE_IDX, 8'h20);
    settle();
    check(32'(fullscale_coef), 32'h400200);
    rdchk(FS_MID_IDX, 8'h02);
    i_host.wr(REF_MON_IDX, 8'h20);
    // Excitation and ready bit; revision bits written as ones
    for (int e = 0; e < 16; e++) begin
      i_host.wr(EXC_REV_IDX, {4'hf, 4'(e)});
      settle();
      check(32'(excitation_ua), 32'(exc_tab[e % 8]));
      check(32'(ready_on_output), 32'(e / 8));
      rdchk(EXC_REV_IDX, {REV, 4'(e)});
    end
    // Unmapped place: write lost, reads zero
    i_host.wr(4'hf, 8'h5a);
    rdchk(4'hf, 8'h00);
    rdchk(4'h0, 8'h00);
    rdchk(OFS_LOW_IDX, 8'h11);
    // Write with byte lane 0 disabled is dropped
    i_host.lane_en = 1'b0;
    i_host.wr(OFS_LOW_IDX, 8'hee);
    i_host.lane_en = 1'b1;
    rdchk(OFS_LOW_IDX, 8'h11);
    // Second reset mid-run: cleared offset, trim of gain one again
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    check(32'(offset_coef), 32'h0);
    check(32'(fullscale_coef), 32'h400000);
    check(32'(effective_gain), 32'h1);
    rdchk(OFS_HIGH_IDX, 8'h00);
    rdchk(EXC_REV_IDX, {REV, 4'h0});
    stop_test();
  end
endmodule
